// *** hdl/dpc_config_top.sv ***
// configuration, status and receive filter of a serial datacomm port
// assumes inputs synchronous to mclk; async_mode picks the protocol
`timescale 1ns/1ps
module dpc_config_top (
   input  wire logic                     mclk,         // 250 MHz clock
   input  wire logic                     srst,         // sync reset, high
   input  wire logic                     async_mode,   // 1 async, 0 data link
   input  wire logic [7:0]               sw_speed,     // speed switches
   input  wire logic [7:0]               sw_device_id, // device id switches
   input  wire logic [7:0]               sw_hw_hs,     // handshake switches
   input  wire logic [7:0]               reg_addr,     // register number
   input  wire logic                     reg_wr,       // control write strobe
   input  wire logic                     reg_rd,       // status read strobe
   input  wire logic [7:0]               reg_wdata,    // control value
   output logic      [7:0]               reg_rdata,    // status value
   output logic                          reg_ack,      // access done pulse
   output logic                          reg_err,      // access refused pulse
   input  wire logic                     rx_valid,     // received char valid
   input  wire logic [dpc_pkg::DW-1:0]   rx_data,      // received char
   input  wire logic                     rx_bad,       // parity/framing error
   output logic                          rx_ready,     // queue can take char
   input  wire logic                     nak_rcvd,     // nak seen, pulse
   output logic                          q_valid,      // queue head valid
   output logic      [dpc_pkg::DW-1:0]   q_data,       // queue head char
   input  wire logic                     q_ready,      // consumer takes head
   output logic      [7:0]               rx_speed,     // receive speed code
   output logic      [7:0]               group_id,     // group identifier
   output logic      [7:0]               device_id,    // device identifier
   output logic      [7:0]               hs_type,      // protocol handshake
   output logic      [7:0]               hw_hs,        // hardware handshake
   output logic      [9:0]               blk_limit,    // block limit bytes
   output logic      [7:0]               eol_len       // line end length
);
   import dpc_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic id_ok(input logic [7:0] code);
      return code <= ID_MAX;
   endfunction : id_ok

   function automatic logic [9:0] blk_bytes(input logic [7:0] code);
      return (code == 8'h00) ? BLK_MAX : {1'b0, code, 1'b0};
   endfunction : blk_bytes

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] rx_speed_reg, group_id_reg, device_id_reg, hs_type_reg;
   logic [7:0] hw_hs_reg, blk_cfg_reg, rx_errs_reg, tx_errs_reg;
   logic [7:0] hs_chr1_reg, hs_chr2_reg, eol_len_reg, eol_chr1_reg;
   logic [9:0] blk_limit_reg;
   logic [7:0] rdata_reg;
   logic       ack_reg, err_reg;

   dpc_fifo_if #(.DW(DW)) fq ();

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire a21 = reg_addr == A_RXSPD_GID;
   wire a22 = reg_addr == A_DID_HSTYP;
   wire a23 = reg_addr == A_HW_HS;
   wire a24 = reg_addr == A_BLK_FILT;
   wire a25 = reg_addr == A_RX_ERRS;
   wire a26 = reg_addr == A_HS_CHR1;
   wire a27 = reg_addr == A_HS_CHR2;
   wire a28 = reg_addr == A_EOL_LEN;
   wire a29 = reg_addr == A_EOL_CHR1;
   wire mapped = (reg_addr >= A_RXSPD_GID) && (reg_addr <= A_EOL_CHR1);
   // async-only range; status 26 stays readable for the nak count
   wire async_only_wr = ((reg_addr >= A_HS_CHR1) && (reg_addr <= A_ASYNC_END))
                        || reg_addr == A_CHAR_GAP || reg_addr == A_BREAK;
   wire async_only_rd = async_only_wr && !a26;
   wire dl = !async_mode;

   // ------------------------------------------------------------
   // write checking
   // ------------------------------------------------------------
   wire bad_code = (a21 && dl && !id_ok(reg_wdata))
                   || (a22 && dl && !id_ok(reg_wdata))
                   || (a22 && async_mode && reg_wdata > HS_TYPE_MAX)
                   || (a23 && reg_wdata > HW_MAX)
                   || (a28 && reg_wdata > EOL_LEN_MAX);
   // out of range codes are refused and leave the register alone
   wire bad_wr = reg_wr && (!mapped || a25 || bad_code
                            || (dl && async_only_wr));
   wire bad_rd = reg_rd && (!mapped || (dl && async_only_rd));
   wire wr_ok  = reg_wr && !bad_wr;
   wire rd_ok  = reg_rd && !bad_rd;

   // ------------------------------------------------------------
   // read selection
   // ------------------------------------------------------------
   wire [7:0] rd_mux =
      a21 ? (async_mode ? rx_speed_reg : group_id_reg) :
      a22 ? (async_mode ? hs_type_reg : device_id_reg) :
      a23 ? hw_hs_reg :
      a24 ? blk_cfg_reg :
      a25 ? rx_errs_reg :
      a26 ? (async_mode ? hs_chr1_reg : tx_errs_reg) :
      a27 ? hs_chr2_reg :
      a28 ? eol_len_reg :
      a29 ? eol_chr1_reg :
      8'h00;

   // ------------------------------------------------------------
   // receive classification and filtering
   // ------------------------------------------------------------
   wire rx_take   = rx_valid && rx_ready;
   wire is_hs     = rx_data == hs_chr1_reg || rx_data == hs_chr2_reg;
   wire is_eol    = eol_len_reg != 8'h00 && rx_data == eol_chr1_reg;
   wire is_prompt = rx_data == CH_PROMPT;
   wire is_nul    = rx_data == CH_NUL;
   wire is_del    = rx_data == CH_DEL;
   wire is_ff     = rx_data == CH_FF;
   // bad chars with substitution on bypass class filtering
   wire subst     = async_mode && rx_bad && blk_cfg_reg[FB_ERR];
   wire drop      = async_mode && !subst && (
                       (is_hs     && !blk_cfg_reg[FB_HS])
                    || (is_eol    && !blk_cfg_reg[FB_EOL])
                    || (is_prompt && !blk_cfg_reg[FB_PROMPT])
                    || (is_nul    && !blk_cfg_reg[FB_NUL])
                    || (is_del    && !blk_cfg_reg[FB_DEL])
                    || (is_ff     && !blk_cfg_reg[FB_FF]));
   assign fq.push_valid = rx_valid && !drop;
   assign fq.push_data  = subst ? CH_UNDER : rx_data;
   assign fq.pop_ready  = q_ready;

   dpc_fifo #(.DW(DW), .DEPTH(DEPTH)) u_fifo (
      .mclk (mclk),
      .srst (srst),
      .fq   (fq)
   );

   // ------------------------------------------------------------
   // identifier and handshake registers
   // ------------------------------------------------------------
   // switches are sampled while srst is held
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_speed_reg  <= sw_speed;
         group_id_reg  <= GID_RST;
         device_id_reg <= sw_device_id;
         hs_type_reg   <= 8'h00;
         hw_hs_reg     <= sw_hw_hs;
      end else if (wr_ok) begin
         if (a21 && async_mode) rx_speed_reg <= reg_wdata;
         if (a21 && dl) group_id_reg <= reg_wdata;
         if (a22 && dl) device_id_reg <= reg_wdata;
         if (a22 && async_mode) hs_type_reg <= reg_wdata;
         if (a23) hw_hs_reg <= reg_wdata;
      end
   end

   // block size or filter mask: one storage, meaning follows the mode
   always_ff @(posedge mclk) begin
      if (srst) begin
         blk_cfg_reg   <= async_mode ? FILT_RST : BLK_DL_RST;
         blk_limit_reg <= BLK_MAX;
      end else if (wr_ok && a24) begin
         blk_cfg_reg   <= reg_wdata;
         blk_limit_reg <= blk_bytes(reg_wdata);
      end
   end

   // async handshake and line end characters
   always_ff @(posedge mclk) begin
      if (srst) begin
         hs_chr1_reg  <= HS1_RST;
         hs_chr2_reg  <= HS2_RST;
         eol_len_reg  <= EOL_LEN_RST;
         eol_chr1_reg <= EOL_CHR_RST;
      end else if (wr_ok) begin
         if (a26) hs_chr1_reg <= reg_wdata;
         if (a27) hs_chr2_reg <= reg_wdata;
         if (a28) eol_len_reg <= reg_wdata;
         if (a29) eol_chr1_reg <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // error counters
   // ------------------------------------------------------------
   // saturate rather than wrap so a flood never reads as few errors
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_errs_reg <= 8'h00;
         tx_errs_reg <= 8'h00;
      end else begin
         if (rx_take && rx_bad && rx_errs_reg != CNT_SAT)
            rx_errs_reg <= rx_errs_reg + 8'h01;
         if (nak_rcvd && dl && tx_errs_reg != CNT_SAT)
            tx_errs_reg <= tx_errs_reg + 8'h01;
      end
   end

   // ------------------------------------------------------------
   // access answer
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
      end else begin
         ack_reg <= reg_wr || reg_rd;
         err_reg <= bad_wr || bad_rd;
         if (reg_rd) rdata_reg <= rd_ok ? rd_mux : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata = rdata_reg;
   assign reg_ack   = ack_reg;
   assign reg_err   = err_reg;
   assign rx_ready  = fq.push_ready;
   assign q_valid   = fq.pop_valid;
   assign q_data    = fq.pop_data;
   assign rx_speed  = rx_speed_reg;
   assign group_id  = group_id_reg;
   assign device_id = device_id_reg;
   assign hs_type   = hs_type_reg;
   assign hw_hs     = hw_hs_reg;
   assign blk_limit = blk_limit_reg;
   assign eol_len   = eol_len_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_gid_reject: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a21 && dl && reg_wdata > ID_MAX
      |=> reg_err && $stable(group_id_reg))
      else $error("bad group id accepted");

   chk_rxspd_write: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a21 && async_mode |=> rx_speed == $past(reg_wdata))
      else $error("receive speed not written");

   chk_hstype_range: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a22 && async_mode && reg_wdata > HS_TYPE_MAX
      |=> reg_err && $stable(hs_type_reg) && hs_type <= HS_TYPE_MAX)
      else $error("bad handshake type accepted");

   chk_hw_range: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a23 && reg_wdata > HW_MAX |=> reg_err && $stable(hw_hs))
      else $error("bad hardware handshake accepted");

   chk_blk_readback: assert property (@(posedge mclk) disable iff (srst)
      (reg_wr && a24 && !reg_rd) ##1 (reg_rd && a24 && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("reg 24 readback differs");

   chk_blk_limit: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a24 |=> blk_limit == (($past(reg_wdata) == 8'h00) ? BLK_MAX
                        : {1'b0, $past(reg_wdata), 1'b0}))
      else $error("block limit wrong");

   chk_nul_drop: assert property (@(posedge mclk) disable iff (srst)
      async_mode && rx_valid && is_nul && !rx_bad && !blk_cfg_reg[FB_NUL]
      |-> !fq.push_valid)
      else $error("nul passed while masked");

   chk_err_subst: assert property (@(posedge mclk) disable iff (srst)
      async_mode && rx_valid && rx_bad && blk_cfg_reg[FB_ERR]
      |-> fq.push_valid && fq.push_data == CH_UNDER)
      else $error("bad char not replaced");

   chk_rxerr_count: assert property (@(posedge mclk) disable iff (srst)
      rx_take && rx_bad && rx_errs_reg != CNT_SAT
      |=> rx_errs_reg == $past(rx_errs_reg) + 8'h01)
      else $error("receive error not counted");

   chk_dl_block: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && dl && a27 |=> reg_err && $stable(hs_chr2_reg))
      else $error("async register written in data link");

   chk_nak_count: assert property (@(posedge mclk) disable iff (srst)
      nak_rcvd && dl && tx_errs_reg != CNT_SAT
      |=> tx_errs_reg == $past(tx_errs_reg) + 8'h01)
      else $error("nak not counted");

   chk_eol_len: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a28 && reg_wdata > EOL_LEN_MAX |=> reg_err && eol_len <= EOL_LEN_MAX)
      else $error("bad line end length accepted");

   // ------------------------------------------------------------
   // write, read, refusal, filter and counter checks
   // ------------------------------------------------------------
   // a refused write must leave state alone, else one typo reconfigures the link
   chk_gid_write: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a21 && dl |=> group_id == $past(reg_wdata))
      else $error("group id not written");
   chk_did_reject: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && a22 && dl && reg_wdata > ID_MAX
      |=> reg_err && $stable(device_id_reg))
      else $error("bad device id accepted");
   chk_hw_write: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a23 |=> hw_hs == $past(reg_wdata))
      else $error("hardware handshake not written");
   chk_blk_gap_read: assert property (@(posedge mclk) disable iff (srst)
      (reg_wr && a24 && !reg_rd) ##1 (!reg_wr && !reg_rd) ##1 (reg_rd && a24 && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("reg 24 readback after gap differs");
   chk_rdata_hold: assert property (@(posedge mclk) disable iff (srst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_eol_drop: assert property (@(posedge mclk) disable iff (srst)
      async_mode && rx_valid && is_eol && !rx_bad && !blk_cfg_reg[FB_EOL]
      |-> !fq.push_valid)
      else $error("line end passed while masked");
   chk_errcnt_hold: assert property (@(posedge mclk) disable iff (srst)
      !(rx_take && rx_bad) |=> $stable(rx_errs_reg))
      else $error("receive error count moved");
   chk_hs1_reject: assert property (@(posedge mclk) disable iff (srst)
      reg_wr && dl && a26 |=> reg_err && $stable(hs_chr1_reg))
      else $error("handshake char written in data link");
   chk_nak_read: assert property (@(posedge mclk) disable iff (srst)
      reg_rd && dl && a26 |=> !reg_err && reg_rdata == $past(tx_errs_reg))
      else $error("nak count not returned");
   chk_hs1_write: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a26 |=> hs_chr1_reg == $past(reg_wdata))
      else $error("first handshake char not written");
   chk_hs2_write: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a27 |=> hs_chr2_reg == $past(reg_wdata))
      else $error("second handshake char not written");
   chk_eol_read: assert property (@(posedge mclk) disable iff (srst)
      reg_rd && a29 && async_mode |=> reg_rdata == $past(eol_chr1_reg))
      else $error("line end char not returned");
   chk_eol_chr: assert property (@(posedge mclk) disable iff (srst)
      wr_ok && a29 |=> eol_chr1_reg == $past(reg_wdata))
      else $error("line end char not written");
   chk_unmapped: assert property (@(posedge mclk) disable iff (srst)
      (reg_wr || reg_rd) && !mapped |=> reg_err)
      else $error("unmapped access not refused");
   chk_err_ack: assert property (@(posedge mclk) disable iff (srst)
      reg_err |-> reg_ack)
      else $error("refusal without answer");
endmodule : dpc_config_top

// *** hdl/dpc_pkg.sv ***
// constants shared by the datacomm configuration block and its queue
// assumes one 250 MHz clock and numbered register access
package dpc_pkg;
   // ------------------------------------------------------------
   // register numbers
   // ------------------------------------------------------------
   localparam logic [7:0] A_RXSPD_GID = 8'h15;
   localparam logic [7:0] A_DID_HSTYP = 8'h16;
   localparam logic [7:0] A_HW_HS     = 8'h17;
   localparam logic [7:0] A_BLK_FILT  = 8'h18;
   localparam logic [7:0] A_RX_ERRS   = 8'h19;
   localparam logic [7:0] A_HS_CHR1   = 8'h1A;
   localparam logic [7:0] A_HS_CHR2   = 8'h1B;
   localparam logic [7:0] A_EOL_LEN   = 8'h1C;
   localparam logic [7:0] A_EOL_CHR1  = 8'h1D;
   localparam logic [7:0] A_ASYNC_END = 8'h23;
   localparam logic [7:0] A_CHAR_GAP  = 8'h25;
   localparam logic [7:0] A_BREAK     = 8'h27;
   // ------------------------------------------------------------
   // reset values and accepted code limits
   // ------------------------------------------------------------
   localparam logic [7:0] GID_RST     = 8'h01;
   localparam logic [7:0] BLK_DL_RST  = 8'h00;
   localparam logic [7:0] FILT_RST    = 8'h7F;
   localparam logic [7:0] HS1_RST     = 8'h11;
   localparam logic [7:0] HS2_RST     = 8'h13;
   localparam logic [7:0] EOL_LEN_RST = 8'h02;
   localparam logic [7:0] EOL_CHR_RST = 8'h0D;
   localparam logic [7:0] ID_MAX      = 8'h1A;
   localparam logic [7:0] HS_TYPE_MAX = 8'h05;
   localparam logic [7:0] HW_MAX      = 8'h03;
   localparam logic [7:0] EOL_LEN_MAX = 8'h02;
   localparam logic [9:0] BLK_MAX     = 10'h200;
   // ------------------------------------------------------------
   // receive filter mask bits and special characters
   // ------------------------------------------------------------
   localparam int FB_HS     = 0;
   localparam int FB_EOL    = 1;
   localparam int FB_PROMPT = 2;
   localparam int FB_NUL    = 3;
   localparam int FB_DEL    = 4;
   localparam int FB_FF     = 5;
   localparam int FB_ERR    = 6;
   localparam logic [7:0] CH_NUL    = 8'h00;
   localparam logic [7:0] CH_DEL    = 8'h7F;
   localparam logic [7:0] CH_FF     = 8'hFF;
   localparam logic [7:0] CH_UNDER  = 8'h5F;
   localparam logic [7:0] CH_PROMPT = 8'h11;
   localparam logic [7:0] CNT_SAT   = 8'hFF;
   localparam int DW    = 8;
   localparam int DEPTH = 32;
endpackage : dpc_pkg

// *** hdl/dpc_fifo_if.sv ***
// push and pop signals between the filter and the receive queue
// assumes both ends share mclk
`timescale 1ns/1ps
interface dpc_fifo_if #(parameter int DW = 8);
   logic          push_valid;
   logic          push_ready;
   logic [DW-1:0] push_data;
   logic          pop_valid;
   logic          pop_ready;
   logic [DW-1:0] pop_data;
   modport fill  (output push_valid, push_data, pop_ready,
                  input  push_ready, pop_valid, pop_data);
   modport store (input  push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
endinterface : dpc_fifo_if

// *** hdl/dpc_fifo.sv ***
// receive queue with registered read data and registered flags
// assumes synchronous active-high reset, DEPTH a power of two
`timescale 1ns/1ps
module dpc_fifo #(
   parameter int DW    = 8,
   parameter int DEPTH = 32
) (
   input wire logic mclk,   // system clock
   input wire logic srst,   // synchronous reset
   dpc_fifo_if.store fq     // push and pop side
);
   localparam int AW = $clog2(DEPTH);
   logic [DW-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
   logic [AW:0]   count_reg, count_next;
   logic          room_reg, out_valid_reg;
   logic [DW-1:0] out_data_reg;
   wire           do_wr = fq.push_valid && room_reg;
   wire           do_rd = (count_reg != '0) && (!out_valid_reg || fq.pop_ready);
   // count tracks the memory only; the output stage is an extra slot outside it
   assign count_next    = count_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
   assign fq.push_ready = room_reg;
   assign fq.pop_valid  = out_valid_reg;
   assign fq.pop_data   = out_data_reg;
   // storage array, no reset needed
   always_ff @(posedge mclk) begin
      if (do_wr) mem[wr_ptr_reg] <= fq.push_data;
   end
   // pointers, count and flags
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         count_reg     <= '0;
         room_reg      <= 1'b0;
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end else begin
         count_reg <= count_next;
         room_reg  <= count_next != (AW+1)'(DEPTH);
         if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_rd) begin
            rd_ptr_reg    <= rd_ptr_reg + 1'b1;
            out_data_reg  <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
         end else if (fq.pop_ready) begin
            out_valid_reg <= 1'b0;
         end
      end
   end
endmodule : dpc_fifo

// *** tb/dpc_remote_model.sv ***
// far end of the serial line: offers received chars and nak pulses
// assumes the bench queues chars with send and naks with nak
`timescale 1ns/1ps
module dpc_remote_model (
   input  wire logic       mclk,     // system clock
   input  wire logic       rx_ready, // queue has room
   output logic            rx_valid, // char offered
   output logic      [7:0] rx_data,  // char value
   output logic            rx_bad,   // parity or framing error
   output logic            nak_rcvd  // nak pulse
);
   logic [8:0] pend_q[$];
   initial {rx_valid, rx_bad, nak_rcvd, rx_data} = 11'h000;
   task automatic send(input logic [7:0] d, input logic b);
      pend_q.push_back({b, d});
   endtask : send
   task automatic nak();
      @(posedge mclk);
      nak_rcvd <= 1'b1;
      @(posedge mclk);
      nak_rcvd <= 1'b0;
   endtask : nak
   // offer held until taken; idle data flips so a stale char never looks fresh
   always @(posedge mclk) begin
      if (!rx_valid || rx_ready) begin
         rx_valid <= pend_q.size() > 0;
         if (pend_q.size() > 0) {rx_bad, rx_data} <= pend_q.pop_front();
         else rx_data <= ~rx_data;
      end
   end
endmodule : dpc_remote_model

// *** tb/tb.sv ***
// self-checking bench for the datacomm configuration block
// assumes the remote model stands on the receive side
`timescale 1ns/1ps
module tb;
   import dpc_pkg::*;
   logic       mclk, srst, async_mode, reg_wr, reg_rd, q_ready, hold, rx_ready, rx_valid;
   logic       rx_bad, nak_rcvd, reg_ack, reg_err, q_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_data, q_data, rx_speed, group_id;
   logic [7:0] device_id, hs_type, hw_hs, eol_len;
   logic [9:0] blk_limit, ent;
   logic [7:0] rch;
   logic [7:0] drop_set [7] = '{8'h00, 8'h7F, 8'hFF, 8'h06, 8'h05, 8'h0D, 8'h11};
   logic [31:0] lfsr_st = 32'h1cd8;
   logic [9:0] exp_reg_q[$];
   logic [7:0] exp_chr_q[$];
   int         num_errors, n_checks;
   dpc_config_top dut_u (.mclk, .srst, .async_mode, .sw_speed(8'h0E), .sw_device_id(8'h03),
      .sw_hw_hs(8'h02), .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_ack,
      .reg_err, .rx_valid, .rx_data, .rx_bad, .rx_ready, .nak_rcvd, .q_valid, .q_data,
      .q_ready, .rx_speed, .group_id, .device_id, .hs_type, .hw_hs, .blk_limit, .eol_len);
   dpc_remote_model rm_u (.mclk, .rx_ready, .rx_valid, .rx_data, .rx_bad, .nak_rcvd);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   function automatic logic [7:0] rnd();
      lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
      return lfsr_st[7:0];
   endfunction : rnd
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one register access; the note is taken before the strobe goes out
   task automatic acc(input logic wr, input logic [7:0] a, d, input logic e, input logic [7:0] r);
      @(posedge mclk);
      exp_reg_q.push_back({!wr, e, r});
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
      @(posedge mclk);
      {reg_wr, reg_rd} <= 2'b00;
   endtask : acc
   task automatic tx(input logic [7:0] d, input logic b, k, input logic [7:0] x);
      rm_u.send(d, b);
      if (k) exp_chr_q.push_back(x);
   endtask : tx
   task automatic drain();
      for (int i = 0; i < 300 && exp_chr_q.size() > 0; i++) @(posedge mclk);
      chk("left", exp_chr_q.size(), 0);
   endtask : drain
   // watcher: consumer taking chars at random and the register answers
   always @(posedge mclk) begin
      q_ready <= !hold && rnd() > 8'h50;
      if (reg_ack && exp_reg_q.size() > 0) begin
         ent = exp_reg_q.pop_front();
         chk("reg_err", reg_err, ent[8]);
         if (ent[9]) chk("reg_rdata", reg_rdata, ent[7:0]);
      end
      if (q_valid && q_ready && exp_chr_q.size() > 0) chk("q_data", q_data, exp_chr_q.pop_front());
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   initial begin
      #60000;
      num_errors++;
      print_verdict();
   end
   initial begin
      {srst, reg_wr, reg_rd, hold, async_mode} = 5'b10001;
      {reg_addr, reg_wdata} = 16'h0000;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      chk("hw_hs", hw_hs, 10'h002);
      chk("blk_limit", blk_limit, 10'h200);
      chk("group_id", group_id, 10'h001);
      acc(0, 8'h15, 0, 0, 8'h0E);
      acc(0, 8'h17, 0, 0, 8'h02);
      acc(0, 8'h18, 0, 0, 8'h7F);
      acc(0, 8'h1A, 0, 0, 8'h11);
      acc(0, 8'h1B, 0, 0, 8'h13);
      acc(0, 8'h1C, 0, 0, 8'h02);
      acc(0, 8'h1D, 0, 0, 8'h0D);
      $display("test reset_values done");
      acc(1, 8'h1C, 8'h03, 1, 0);
      acc(1, 8'h1C, 8'h01, 0, 0);
      acc(0, 8'h1C, 0, 0, 8'h01);
      for (int i = 0; i < 7; i++) acc(1, 8'h16, i[7:0], i > 5, 0);
      acc(1, 8'h17, 8'h04, 1, 0);
      acc(1, 8'h17, 8'h01, 0, 0);
      acc(1, 8'h19, 8'h01, 1, 0);
      acc(0, 8'h14, 0, 1, 0);
      acc(1, 8'h1A, 8'h06, 0, 0);
      acc(0, 8'h1A, 0, 0, 8'h06);
      acc(1, 8'h1B, 8'h05, 0, 0);
      acc(0, 8'h1B, 0, 0, 8'h05);
      acc(1, 8'h15, 8'h09, 0, 0);
      @(posedge mclk);
      chk("hs_type", hs_type, 10'h005);
      chk("rx_speed", rx_speed, 10'h009);
      chk("eol_len", eol_len, 10'h001);
      chk("hw_hs", hw_hs, 10'h001);
      $display("test ranges done");
      // handshake char kept, then classes deleted and bad chars replaced
      tx(8'h00, 0, 1, 8'h00);
      tx(8'h06, 0, 1, 8'h06);
      drain();
      acc(1, 8'h18, 8'h40, 0, 0);
      foreach (drop_set[i]) tx(drop_set[i], 0, 0, 0);
      tx(8'h41, 0, 1, 8'h41);
      tx(8'h42, 1, 1, 8'h5F);
      drain();
      acc(1, 8'h18, 8'h00, 0, 0);
      tx(8'h43, 1, 1, 8'h43);
      drain();
      acc(0, 8'h18, 0, 0, 8'h00);
      acc(0, 8'h19, 0, 0, 8'h02);
      acc(1, 8'h1D, 8'h0A, 0, 0);
      acc(0, 8'h1D, 0, 0, 8'h0A);
      $display("test filter done");
      async_mode <= 1'b0;
      acc(1, 8'h15, 8'h1B, 1, 0);
      acc(1, 8'h15, 8'h1A, 0, 0);
      acc(1, 8'h18, 8'h03, 0, 0);
      acc(1, 8'h1A, 8'h06, 1, 0);
      acc(0, 8'h16, 0, 0, 8'h03);
      acc(1, 8'h16, 8'h20, 1, 0);
      acc(1, 8'h1B, 8'h13, 1, 0);
      chk("device_id", device_id, 10'h003);
      rm_u.nak();
      rm_u.nak();
      acc(0, 8'h1A, 0, 0, 8'h02);
      chk("group_id", group_id, 10'h01A);
      chk("blk_limit", blk_limit, 10'h006);
      acc(1, 8'h18, 8'hFF, 0, 0);
      acc(0, 8'h18, 0, 0, 8'hFF);
      @(posedge mclk);
      chk("blk_limit", blk_limit, 10'h1FE);
      hold <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         rch = rnd();
         tx(rch, 0, 1, rch);
      end
      repeat (80) @(posedge mclk);
      chk("rx_ready", rx_ready, 0);
      hold <= 1'b0;
      drain();
      $display("test data_link done");
      print_verdict();
   end
endmodule : tb
